// ---- qfb_ctrl.v ----
// Switch-off, current limit, burst mode and restart mapping for a flyback controller.
// Function
// RULE_01: Sense above feedback clears gate flip-flop.
// RULE_02: Blank switch-off comparator after each turn-on.
// RULE_03: Force gate low after maximum on-time.
// RULE_04: Current limit turns gate off immediately.
// RULE_05: Peak limit and valley count follow line.
// RULE_06: Level 1 uses 0.31/0.90/2.75 V.
// RULE_07: Level 2 uses 0.35/1.05 V.
// RULE_08: Reference-good low clears detection latch.
// RULE_09: Latch clear and off: selection source on.
// RULE_10: At supply-on sample feedback, set latch.
// RULE_11: Latched thresholds never change afterwards.
// RULE_12: Reconnect pull-up 2 us after supply-on.
// RULE_13: Burst entry needs both conditions for 20 ms.
// RULE_14: Entry sets the burst-mode flip-flop.
// RULE_15: Burst-on threshold resumes switching.
// RULE_16: Burst turn-on at valley 8 or 10.
// RULE_17: Burst turn-off at burst current limit.
// RULE_18: Burst-off threshold stops switching until burst-on.
// RULE_19: Exit threshold returns to normal control.
// RULE_20: On exit load counter 1 or 3.
// RULE_21: Line OV, brownout, temperature: non-switching restart.
// RULE_22: Supply OV, overload, out OV, short: odd-skip.
// RULE_23: Mask protections per burst phase.
// RULE_24: Counter bounded 1..8 or 3..10.
// RULE_25: Timers are parameterised clock counters.
// RULE_26: Analogue comparators synchronised before use.
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "qfb_consts.vh"

module qfb_ctrl #(
  parameter LEB_NS      = 250,
  parameter ONMAX_NS    = 25000,
  parameter BEB_CYC     = `QFB_BEB_MS * (`QFB_CLK_KHZ)
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output reg  [31:0] hrdata,
  output wire        hresp,
  input  wire        cs_above_fb,
  input  wire        cs_over_limit,
  input  wire        cs_over_burst_limit,
  input  wire        fb_below_entry,
  input  wire        fb_above_exit,
  input  wire        fb_above_burst_on,
  input  wire        fb_below_burst_off,
  input  wire        fb_above_sel_ref,
  input  wire        ref_good,
  input  wire        vcc_on,
  input  wire        high_line,
  input  wire        fault_line_ov,
  input  wire        fault_brownout,
  input  wire        fault_over_temp,
  input  wire        fault_vcc_ov,
  input  wire        fault_vcc_uv,
  input  wire        fault_overload,
  input  wire        fault_out_ov,
  input  wire        fault_cs_short,
  input  wire        turn_on_req,
  input  wire        cnt_up,
  input  wire        cnt_down,
  input  wire        cnt_reset,
  output wire        gate_drive,
  output wire        feedback_pullup_resistor_on,
  output wire        sel_current_on,
  output wire        burst_mode,
  output wire        burst_switching,
  output wire        peak_limit_high_line,
  output wire [3:0]  valley_count,
  output wire [11:0] burst_current_limit,
  output wire [11:0] burst_entry_threshold,
  output wire [11:0] burst_exit_threshold,
  output wire        restart_non_switch,
  output wire        restart_plain,
  output wire        restart_odd_skip
);

  localparam LEB_CYC   = (LEB_NS * (`QFB_CLK_KHZ / 1000) + 999) / 1000;
  localparam ONMAX_CYC = (ONMAX_NS * (`QFB_CLK_KHZ / 1000)) / 1000;
  localparam ISEL_CYC  = `QFB_ISEL_OFF_CYC;

  // Burst controller states, one-hot.
  localparam [2:0] ST_NORMAL = 3'b001;
  localparam [2:0] ST_BOFF   = 3'b010;
  localparam [2:0] ST_BON    = 3'b100;

  // Two-stage synchronisers; the first stage feeds only the second.
  wire [`QFB_SYNC_W-1:0] async_in;
  reg  [`QFB_SYNC_W-1:0] meta_r;
  reg  [`QFB_SYNC_W-1:0] sync_r;

  assign async_in = {fault_cs_short, fault_out_ov, fault_overload, fault_vcc_uv,
                     fault_vcc_ov, fault_over_temp, fault_brownout, fault_line_ov,
                     high_line, vcc_on, ref_good, fb_above_sel_ref, fb_below_burst_off,
                     fb_above_burst_on, fb_above_exit, fb_below_entry,
                     cs_over_burst_limit, cs_over_limit, cs_above_fb, 2'b00};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_r <= {`QFB_SYNC_W{1'b0}};
      sync_r <= {`QFB_SYNC_W{1'b0}};
    end
    else
    begin
      meta_r <= async_in; // RULE_26
      sync_r <= meta_r;   // RULE_26
    end
  end

  wire       s_cs_fb    = sync_r[2];
  wire       s_cs_lim   = sync_r[3];
  wire       s_cs_blim  = sync_r[4];
  wire       s_fb_entry = sync_r[5];
  wire       s_fb_exit  = sync_r[6];
  wire       s_fb_bon   = sync_r[7];
  wire       s_fb_boff  = sync_r[8];
  wire       s_fb_sel   = sync_r[9];
  wire       s_ref_good = sync_r[10];
  wire       s_vcc_on   = sync_r[11];
  wire       s_hl       = sync_r[12];
  wire [7:0] s_fault    = sync_r[20:13];

  // AHB-Lite slave: zero wait states, always OKAY.
  reg        wr_pend_r;
  reg  [7:0] addr_r;
  reg  [31:0] ctrl_r;
  wire       acc = hsel & hready & htrans[1];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      ctrl_r    <= `QFB_CTRL_RST;
    end
    else
    begin
      wr_pend_r <= acc & hwrite;
      if (acc)
        addr_r <= haddr[7:0];
      if (wr_pend_r && addr_r == `QFB_OFS_CTRL)
        ctrl_r <= {31'h0, hwdata[`QFB_CTRL_EN_BIT]};
    end
  end

  wire sw_enable = ctrl_r[`QFB_CTRL_EN_BIT];

  // Burst level detection latch and selection current source.
  reg        latch_r;
  reg        level2_r;
  reg        vcc_on_d_r;
  reg        isel_r;
  reg  [7:0] isel_cnt_r;
  wire       vcc_rise = s_vcc_on & ~vcc_on_d_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latch_r    <= 1'b0;
      level2_r   <= 1'b0;
      vcc_on_d_r <= 1'b0;
      isel_r     <= 1'b1;
      isel_cnt_r <= 8'h00;
    end
    else
    begin
      vcc_on_d_r <= s_vcc_on;
      if (!s_ref_good)
        latch_r <= 1'b0;                // RULE_08
      else if (vcc_rise && !latch_r)
      begin
        level2_r <= ~s_fb_sel;          // RULE_10 RULE_11
        latch_r  <= 1'b1;               // RULE_10
      end
      // The source stays on until the count after supply-on runs out.
      if (!latch_r && !s_vcc_on)
      begin
        isel_r     <= 1'b1;             // RULE_09
        isel_cnt_r <= 8'h00;
      end
      else if (isel_r && s_vcc_on)
      begin
        if (isel_cnt_r == ISEL_CYC[7:0] - 8'h01)
          isel_r <= 1'b0;               // RULE_12
        isel_cnt_r <= isel_cnt_r + 8'h01;
      end
    end
  end

  assign sel_current_on              = isel_r;
  assign feedback_pullup_resistor_on = ~isel_r;

  // Burst thresholds driven to the analogue section from flip-flops.
  reg [11:0] bcs_r;
  reg [11:0] bent_r;
  reg [11:0] bexit_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bcs_r   <= `QFB_BL1_CS_MV;
      bent_r  <= `QFB_BL1_ENTRY_MV;
      bexit_r <= `QFB_EXIT_MV;
    end
    else
    begin
      bcs_r   <= level2_r ? `QFB_BL2_CS_MV : `QFB_BL1_CS_MV;       // RULE_06 RULE_07
      bent_r  <= level2_r ? `QFB_BL2_ENTRY_MV : `QFB_BL1_ENTRY_MV; // RULE_06 RULE_07
      bexit_r <= `QFB_EXIT_MV;                                     // RULE_06
    end
  end

  assign burst_current_limit   = bcs_r;
  assign burst_entry_threshold = bent_r;
  assign burst_exit_threshold  = bexit_r;

  // Up/down counter with line-dependent bounds.
  reg  [3:0] cnt_r;
  reg  [2:0] st_r;
  reg  [2:0] st_nxt;
  wire [3:0] cnt_min = s_hl ? `QFB_CNT_MIN_HL : `QFB_CNT_MIN_LL;
  wire [3:0] cnt_max = s_hl ? `QFB_CNT_MAX_HL : `QFB_CNT_MAX_LL;
  wire       exit_now = (st_r != ST_NORMAL) && s_fb_exit;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_r <= `QFB_CNT_MIN_LL;
    else if (exit_now || cnt_reset || vcc_rise)
      cnt_r <= cnt_min;                 // RULE_20
    else if (cnt_r < cnt_min)
      cnt_r <= cnt_min;                 // RULE_24
    else if (cnt_r > cnt_max)
      cnt_r <= cnt_max;                 // RULE_24
    else if (cnt_up && cnt_r != cnt_max)
      cnt_r <= cnt_r + 4'd1;            // RULE_24
    else if (cnt_down && cnt_r != cnt_min)
      cnt_r <= cnt_r - 4'd1;            // RULE_24
  end

  // Burst entry blanking counter; it restarts whenever a condition drops.
  reg  [31:0] beb_cnt_r;
  wire        entry_cond = s_fb_entry && (cnt_r == cnt_max) && latch_r;
  wire        entry_done = entry_cond && (beb_cnt_r == BEB_CYC - 1);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      beb_cnt_r <= 32'h0;
    else if (!entry_cond || st_r != ST_NORMAL)
      beb_cnt_r <= 32'h0;
    else if (!entry_done)
      beb_cnt_r <= beb_cnt_r + 32'h1;   // RULE_13 RULE_25
  end

  // Burst state machine: exit has priority over burst on and off.
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      ST_NORMAL:
        if (entry_done)
          st_nxt = ST_BOFF;             // RULE_13 RULE_14
      ST_BOFF:
        if (s_fb_exit)
          st_nxt = ST_NORMAL;           // RULE_19
        else if (s_fb_bon)
          st_nxt = ST_BON;              // RULE_15
      ST_BON:
        if (s_fb_exit)
          st_nxt = ST_NORMAL;           // RULE_19
        else if (s_fb_boff)
          st_nxt = ST_BOFF;             // RULE_18
      default:
        st_nxt = ST_NORMAL;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= ST_NORMAL;
    else
      st_r <= st_nxt;                   // RULE_14
  end

  wire in_burst = (st_r != ST_NORMAL);
  assign burst_mode      = in_burst;
  assign burst_switching = (st_r == ST_BON);
  assign valley_count    = in_burst ? cnt_max : cnt_r;  // RULE_05 RULE_16
  assign peak_limit_high_line = s_hl;                   // RULE_05

  // Protection masking and restart mode mapping.
  wire f_line_ov  = s_fault[0];
  wire f_bo       = s_fault[1];
  wire f_otp      = s_fault[2];
  wire f_vcc_ov   = s_fault[3] & (st_r != ST_BOFF);     // RULE_23
  wire f_vcc_uv   = s_fault[4];
  wire f_ol       = s_fault[5] & ~in_burst;             // RULE_23
  wire f_out_ov   = s_fault[6] & (st_r != ST_BOFF);     // RULE_23
  wire f_cs_short = s_fault[7] & (st_r != ST_BOFF);     // RULE_23
  reg  rs_ns_r;
  reg  rs_pl_r;
  reg  rs_os_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rs_ns_r <= 1'b0;
      rs_pl_r <= 1'b0;
      rs_os_r <= 1'b0;
    end
    else
    begin
      rs_ns_r <= f_line_ov | f_bo | f_otp;                 // RULE_21
      rs_pl_r <= f_vcc_uv;                                 // RULE_22
      rs_os_r <= f_vcc_ov | f_ol | f_out_ov | f_cs_short;  // RULE_22
    end
  end

  assign restart_non_switch = rs_ns_r;
  assign restart_plain      = rs_pl_r;
  assign restart_odd_skip   = rs_os_r;
  wire   prot_any = rs_ns_r | rs_pl_r | rs_os_r;

  // Output flip-flop with one on-time counter that also times blanking.
  reg         gate_r;
  reg  [15:0] on_cnt_r;
  wire        may_switch = sw_enable && latch_r && s_vcc_on && !prot_any && (st_r != ST_BOFF);
  wire        blanked    = (on_cnt_r < LEB_CYC);
  wire        pwm_off    = in_burst ? s_cs_blim : s_cs_fb;  // RULE_17
  wire        on_max     = (on_cnt_r >= ONMAX_CYC - 1);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gate_r   <= 1'b0;
      on_cnt_r <= 16'h0;
    end
    else if (!gate_r)
    begin
      on_cnt_r <= 16'h0;
      if (turn_on_req && may_switch)
        gate_r <= 1'b1;
    end
    else
    begin
      on_cnt_r <= on_cnt_r + 16'h1;     // RULE_25
      if (!may_switch)
        gate_r <= 1'b0;                 // RULE_18
      else if (s_cs_lim)
        gate_r <= 1'b0;                 // RULE_04
      else if (on_max)
        gate_r <= 1'b0;                 // RULE_03
      else if (!blanked && pwm_off)
        gate_r <= 1'b0;                 // RULE_01 RULE_02 RULE_17
    end
  end

  assign gate_drive = gate_r;

  // Read mux; unmapped offsets read zero.
  always @*
  begin
    case (addr_r)
      `QFB_OFS_CTRL:   hrdata = ctrl_r;
      `QFB_OFS_STATUS: hrdata = {20'h0, cnt_r, st_r, level2_r, latch_r,
                                 isel_r, burst_switching, gate_r};
      `QFB_OFS_FAULT:  hrdata = {21'h0, rs_os_r, rs_pl_r, rs_ns_r, s_fault};
      default:         hrdata = 32'h0;
    endcase
  end

endmodule // qfb_ctrl

// ---- qfb_consts.vh ----
// Constants for the quasi-resonant flyback switch-off and burst controller.
`ifndef QFB_CONSTS_VH
`define QFB_CONSTS_VH

// Register byte offsets on the AHB-Lite slave.
`define QFB_OFS_CTRL        8'h00
`define QFB_OFS_STATUS      8'h04
`define QFB_OFS_FAULT       8'h08

// Control register fields and reset value.
`define QFB_CTRL_EN_BIT     0
`define QFB_CTRL_RST        32'h0000_0001

// Clock rate in kHz, used to turn times into cycle counts.
`define QFB_CLK_KHZ         20000

// Selection current source stays on this long after supply-on, in ns.
`define QFB_ISEL_OFF_NS     2000
`define QFB_ISEL_OFF_CYC    ((`QFB_ISEL_OFF_NS * `QFB_CLK_KHZ + 999999) / 1000000)

// Burst entry blanking time in ms.
`define QFB_BEB_MS          20

// Burst level thresholds in mV.
`define QFB_BL1_CS_MV       12'd310
`define QFB_BL1_ENTRY_MV    12'd900
`define QFB_BL2_CS_MV       12'd350
`define QFB_BL2_ENTRY_MV    12'd1050
`define QFB_EXIT_MV         12'd2750

// Up/down counter and valley count bounds for low and high line.
`define QFB_CNT_MIN_LL      4'd1
`define QFB_CNT_MAX_LL      4'd8
`define QFB_CNT_MIN_HL      4'd3
`define QFB_CNT_MAX_HL      4'd10

// Width of the synchronised analogue input vector.
`define QFB_SYNC_W          21

`endif

// ---- qfb_ctrl_monitor.sv ----
// Assertion checker for the flyback switch-off and burst controller ports.
`timescale 1ns/1ps
module qfb_ctrl_monitor #(
  parameter ONMAX_NS = 25000,
  parameter BEB_CYC  = 20
) (
  input wire       hclk,
  input wire       hresetn,
  input wire       gate_drive,
  input wire       cs_above_fb,
  input wire       cs_over_limit,
  input wire       cs_over_burst_limit,
  input wire       fb_below_entry,
  input wire       ref_good,
  input wire       vcc_on,
  input wire       fault_line_ov,
  input wire       fault_vcc_uv,
  input wire       sel_current_on,
  input wire       burst_mode,
  input wire       burst_switching,
  input wire       peak_limit_high_line,
  input wire [3:0] valley_count,
  input wire       restart_non_switch,
  input wire       restart_plain
);
  localparam int ONMAX = ONMAX_NS / 50;
  logic [2:0]  lim_r;
  logic [19:0] hi_r;
  logic [19:0] low_r;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Limit hits reach the gate through a synchroniser, so they are remembered for three cycles.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lim_r <= 3'h0;
      hi_r  <= 20'h0;
      low_r <= 20'h0;
    end
    else
    begin
      lim_r <= {lim_r[1:0], cs_over_limit};
      hi_r  <= gate_drive ? hi_r + 20'h1 : 20'h0;
      low_r <= fb_below_entry ? low_r + 20'h1 : 20'h0;
    end
  end

  sequence s_gate_on;
    $rose(gate_drive);
  endsequence
  sequence s_blank_hold;
    (gate_drive || cs_over_limit || |lim_r)[*5];
  endsequence

  a_blank_hold: assert property (s_gate_on |-> s_blank_hold)
    else $error("gate dropped inside blanking");
  a_onmax_cut: assert property (hi_r <= ONMAX + 1)
    else $error("gate high past maximum on-time");
  a_limit_off: assert property (gate_drive && cs_over_limit |-> ##[1:3] !gate_drive)
    else $error("current limit did not open the switch");
  a_fb_off: assert property (gate_drive && !burst_mode && cs_above_fb && hi_r > 8 |-> ##[1:3] !gate_drive)
    else $error("sense above feedback left gate on");
  a_burst_cs_off: assert property (burst_switching && gate_drive && cs_over_burst_limit && hi_r > 8 |->
    ##[1:3] !gate_drive)
    else $error("burst limit did not open the switch");
  a_sel_release: assert property ($rose(vcc_on) && ref_good |-> sel_current_on[*8] ##[30:38] !sel_current_on)
    else $error("selection source release time wrong");
  a_burst_valley: assert property (burst_switching |-> valley_count == (peak_limit_high_line ? 4'ha : 4'h8))
    else $error("burst valley count wrong");
  a_exit_load: assert property ($fell(burst_mode) |-> valley_count == (peak_limit_high_line ? 4'h3 : 4'h1))
    else $error("counter not loaded on burst exit");
  a_entry_wait: assert property ($rose(burst_mode) |-> low_r >= BEB_CYC)
    else $error("burst entered before blanking ran out");
  a_line_fault: assert property (fault_line_ov |-> ##[2:4] restart_non_switch)
    else $error("line fault without non-switching restart");
  a_uv_fault: assert property (fault_vcc_uv |-> ##[2:4] restart_plain)
    else $error("undervoltage without plain restart");
endmodule // qfb_ctrl_monitor

bind qfb_ctrl qfb_ctrl_monitor #(.ONMAX_NS(ONMAX_NS), .BEB_CYC(BEB_CYC)) mon_u (.*);

// ---- qfb_analog_model.sv ----
// Behavioural current-sense ramp standing in for the analogue comparators.
`timescale 1ns/1ps
module qfb_analog_model (
  input  wire        hclk,
  input  wire        gate_drive,
  input  wire [15:0] fb_mv,
  input  wire [15:0] lim_mv,
  input  wire [11:0] burst_current_limit,
  output logic       cs_above_fb,
  output logic       cs_over_limit,
  output logic       cs_over_burst_limit
);
  logic [15:0] cs_r = 16'h0;

  // Sense ramps 10 mV a cycle while the switch conducts and collapses when it opens.
  always @(posedge hclk)
  begin
    cs_r <= gate_drive ? cs_r + 16'ha : 16'h0;
  end

  // Comparators follow the ramp, so no stale trip lingers after the switch opens.
  assign cs_above_fb         = cs_r > fb_mv;
  assign cs_over_limit       = cs_r > lim_mv;
  assign cs_over_burst_limit = cs_r >= {4'h0, burst_current_limit};
endmodule // qfb_analog_model

// ---- qfb_ctrl_test.sv ----
// Self-checking testbench for the flyback switch-off and burst controller.
`timescale 1ns/1ps
module qfb_ctrl_test;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, ref_good, vcc_on, high_line, turn_on_req, cnt_up, cnt_reset;
  logic        fb_below_entry, fb_above_exit, fb_above_burst_on, fb_below_burst_off, fb_above_sel_ref;
  logic        fault_line_ov, fault_brownout, fault_over_temp, fault_vcc_ov;
  logic        fault_vcc_uv, fault_overload, fault_out_ov, fault_cs_short;
  logic        cnt_down, hready, hreadyout, hresp, gate_drive, feedback_pullup_resistor_on, sel_current_on;
  logic        burst_mode, burst_switching, peak_limit_high_line, restart_non_switch, restart_plain;
  logic        restart_odd_skip, cs_above_fb, cs_over_limit, cs_over_burst_limit;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  valley_count;
  logic [11:0] burst_current_limit, burst_entry_threshold, burst_exit_threshold;
  logic [15:0] fb_mv, lim_mv;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [10:0] rows [0:7] = '{11'h00c, 11'h014, 11'h024, 11'h041, 11'h082, 11'h101, 11'h201, 11'h401};
  integer      n_mismatch = 0;
  integer      comparisons = 0;
  integer      w, i;

  assign hready   = hreadyout;
  assign hsize    = 3'h2;
  assign cnt_down = 1'b0;

  qfb_ctrl #(.LEB_NS(250), .ONMAX_NS(25000), .BEB_CYC(20)) dut_u (.*);
  qfb_analog_model model_u (.*);

  always #25 hclk = ~hclk;

  task final_report(input integer t);
    begin
      n_mismatch = n_mismatch + t;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask

  task cyc(input integer n);
    repeat (n) @(posedge hclk);
  endtask

  // Bounded wait for the slave's ready; a stuck bus ends the run as a failure.
  task wrdy;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 20)
      begin
        n = n + 1;
        @(posedge hclk);
      end
      if (n == 20)
        final_report(1);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wrdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wrdy;
      q = hrdata;
    end
  endtask

  task flt(input logic [7:0] f);
    {fault_cs_short, fault_out_ov, fault_overload, fault_vcc_uv,
     fault_vcc_ov, fault_over_temp, fault_brownout, fault_line_ov} <= f;
  endtask

  // Requests one turn-on and counts gate-high cycles at the falling edge, where the gate has settled.
  task pulse(input logic [15:0] f, input logic [15:0] l);
    integer n;
    begin
      fb_mv <= f;
      lim_mv <= l;
      turn_on_req <= 1'b1;
      @(posedge hclk);
      turn_on_req <= 1'b0;
      w = 0;
      for (n = 0; n < 700 && !(w > 0 && gate_drive === 1'b0); n = n + 1)
      begin
        @(negedge hclk);
        if (gate_drive === 1'b1)
          w = w + 1;
      end
      @(posedge hclk);
    end
  endtask

  initial
  begin
    {hresetn, hsel, hwrite, ref_good, vcc_on, high_line, turn_on_req, cnt_up, cnt_reset} = 9'h0;
    {fb_below_entry, fb_above_exit, fb_above_burst_on, fb_below_burst_off, fb_above_sel_ref} = 5'h0;
    {htrans, haddr, hwdata, fb_mv, lim_mv} = 98'h0;
    flt(8'h0);
    cyc(5);
    hresetn <= 1'b1;
    cyc(1);
    chk(sel_current_on, 1);
    chk(valley_count, 1);
    chk(burst_exit_threshold, 32'habe);
    bus(0, 8'h10, 0, r);
    chk(r, 0);
    // Each fault alone must raise exactly its own restart kind.
    for (i = 0; i < 8; i = i + 1)
    begin
      flt(rows[i][10:3]);
      cyc(5);
      chk({restart_non_switch, restart_plain, restart_odd_skip}, rows[i][2:0]);
      bus(0, 8'h08, 0, r);
      chk(r[10:0], {rows[i][0], rows[i][1], rows[i][2], rows[i][10:3]});
      flt(8'h0);
      cyc(5);
    end
    // Level 2 start-up first, level 1 last; the latch must ignore later feedback moves.
    for (i = 0; i < 2; i = i + 1)
    begin
      vcc_on <= 1'b0;
      ref_good <= 1'b0;
      cyc(4);
      bus(0, 8'h04, 0, r);
      chk(r[3], 0);
      chk(sel_current_on, 1);
      fb_above_sel_ref <= i[0];
      ref_good <= 1'b1;
      cyc(4);
      vcc_on <= 1'b1;
      cyc(50);
      chk(sel_current_on, 0);
      chk(feedback_pullup_resistor_on, 1);
      chk(hresp, 0);
      chk({burst_current_limit, burst_entry_threshold}, i ? 32'h136384 : 32'h15e41a);
      fb_above_sel_ref <= ~i[0];
      cyc(4);
      chk(burst_entry_threshold, i ? 32'h384 : 32'h41a);
    end
    // Feedback sits above anything the ramp reaches in 500 cycles, so only the on-time limit can cut.
    pulse(16'h2710, 16'hffff);
    chk(w >= 499 && w <= 501, 1);
    pulse(16'h0, 16'hffff);
    chk(w >= 5 && w <= 8, 1);
    pulse(16'hfa0, 16'h0);
    chk(w < 5, 1);
    bus(1, 8'h00, 0, r);
    pulse(16'h0, 16'hffff);
    chk(w, 0);
    bus(1, 8'h00, 1, r);
    repeat (9)
    begin
      cnt_up <= 1'b1;
      cyc(1);
      cnt_up <= 1'b0;
      cyc(1);
    end
    bus(0, 8'h04, 0, r);
    chk(r[11:8], 8);
    fb_below_entry <= 1'b1;
    cyc(15);
    chk(burst_mode, 0);
    cyc(15);
    chk({burst_mode, burst_switching}, 2);
    flt(8'h08);
    cyc(5);
    chk(restart_odd_skip, 0);
    flt(8'h0);
    fb_above_burst_on <= 1'b1;
    cyc(5);
    chk(burst_switching, 1);
    chk(valley_count, 8);
    flt(8'h20);
    cyc(5);
    chk(restart_odd_skip, 0);
    flt(8'h0);
    pulse(16'h0, 16'hffff);
    chk(w >= 30 && w <= 36, 1);
    fb_above_burst_on <= 1'b0;
    fb_below_burst_off <= 1'b1;
    cyc(5);
    chk(burst_switching, 0);
    pulse(16'h0, 16'hffff);
    chk(w, 0);
    fb_below_burst_off <= 1'b0;
    fb_below_entry <= 1'b0;
    fb_above_exit <= 1'b1;
    cyc(5);
    chk(burst_mode, 0);
    chk(valley_count, 1);
    fb_above_exit <= 1'b0;
    high_line <= 1'b1;
    cyc(4);
    cnt_reset <= 1'b1;
    cyc(1);
    cnt_reset <= 1'b0;
    cyc(4);
    chk(peak_limit_high_line, 1);
    chk(valley_count, 3);
    final_report(0);
  end
endmodule // qfb_ctrl_test
